// ==== src/iowdt_pkg.sv ====
// Package for the I/O port watchdog: port address, timing, types
package iowdt_pkg;
  localparam logic [15:0] IOWDT_PORT_ADDR = 16'h0443;
  localparam logic [7:0] IOWDT_CODE_MIN = 8'h01;
  localparam logic [7:0] IOWDT_CODE_MAX = 8'h3f;
  localparam logic [5:0] IOWDT_INTERVAL_RESET = 6'h00;
  localparam int IOWDT_CLK_MHZ = 250;
  localparam int IOWDT_TICK_S = 1;
  localparam int IOWDT_TICK_CYCLES = IOWDT_TICK_S * IOWDT_CLK_MHZ * 1000000;
  localparam int IOWDT_TICK_W = 28;

  typedef enum logic [2:0] {
    IOWDT_IDLE = 3'b001,
    IOWDT_RUN = 3'b010,
    IOWDT_FIRED = 3'b100
  } iowdt_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iowdt_io_req_t;
endpackage

// ==== src/iowdt_tick.sv ====
// One-second tick divider for the watchdog
`timescale 1ns/10ps
module iowdt_tick #(
  parameter int TICK_CYCLES = iowdt_pkg::IOWDT_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);
  logic [iowdt_pkg::IOWDT_TICK_W-1:0] cnt_reg;
  localparam logic [iowdt_pkg::IOWDT_TICK_W-1:0] LAST = iowdt_pkg::IOWDT_TICK_W'(TICK_CYCLES - 1);

  // Phase restarts on every arm so the first second is full
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (restart || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = (cnt_reg == LAST) && !restart;
endmodule // iowdt_tick

// ==== src/iowdt_top.sv ====
// Watchdog timer programmed through one byte-wide I/O port
`timescale 1ns/10ps
// Function
// - On expiry, reset the processor or interrupt it, as selected.
// - Interval code is a byte written to I/O port 0x443.
// - Code N from 1 to 63 gives a timeout of N seconds; code 0 gives 1 second.
// - Every write restarts the count from the new interval.
// - A read of the port disables the watchdog.
// - A write while disabled starts the watchdog.
module iowdt_top #(
  parameter int TICK_CYCLES = iowdt_pkg::IOWDT_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire iowdt_pkg::iowdt_io_req_t io_req,
  input wire logic irq_mode,
  output logic [7:0] io_rdata,
  output logic cpu_reset,
  output logic cpu_irq,
  output logic running
);
  // ****************************************
  // Decode
  // ****************************************
  logic hit;
  logic port_wr;
  logic port_rd;
  logic tick;
  logic [5:0] count_reg;
  iowdt_pkg::iowdt_state_t state_reg;

  assign hit = io_req.addr == iowdt_pkg::IOWDT_PORT_ADDR;
  assign port_wr = hit && io_req.wr;
  assign port_rd = hit && io_req.rd && !io_req.wr;

  iowdt_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(port_wr),
    .tick(tick)
  );

  // ****************************************
  // State and count
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= iowdt_pkg::IOWDT_IDLE;
    end else if (port_wr) begin
      state_reg <= iowdt_pkg::IOWDT_RUN;
    end else if (port_rd) begin
      state_reg <= iowdt_pkg::IOWDT_IDLE;
    end else begin
      case (state_reg)
        iowdt_pkg::IOWDT_RUN: begin
          if (tick && count_reg <= 6'h01) begin
            state_reg <= iowdt_pkg::IOWDT_FIRED;
          end
        end
        iowdt_pkg::IOWDT_IDLE, iowdt_pkg::IOWDT_FIRED: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= iowdt_pkg::IOWDT_IDLE;
        end
      endcase
    end
  end

  // Only low six bits hold a defined code; upper bits ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= iowdt_pkg::IOWDT_INTERVAL_RESET;
    end else if (port_wr) begin
      count_reg <= io_req.wdata[5:0];
    end else if (state_reg == iowdt_pkg::IOWDT_RUN && tick && count_reg != 6'h00) begin
      count_reg <= count_reg - 6'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (port_rd) begin
      io_rdata <= {2'b00, count_reg};
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign running = state_reg == iowdt_pkg::IOWDT_RUN;
  assign cpu_reset = state_reg == iowdt_pkg::IOWDT_FIRED && !irq_mode;
  assign cpu_irq = state_reg == iowdt_pkg::IOWDT_FIRED && irq_mode;

  // ****************************************
  // Checks
  // ****************************************
  write_arms_a: assert property (@(posedge clk) disable iff (sys_rst)
    port_wr |=> running && count_reg == $past(io_req.wdata[5:0]))
    else $error("write did not arm watchdog");
  read_stops_a: assert property (@(posedge clk) disable iff (sys_rst)
    port_rd |=> !running && !cpu_reset && !cpu_irq)
    else $error("read did not disable watchdog");
  expiry_fires_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && tick && count_reg == 6'h01 && !port_wr && !port_rd |=> (cpu_reset || cpu_irq))
    else $error("expiry did not fire");
  no_early_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && count_reg > 6'h01 && !port_wr |=> !cpu_reset && !cpu_irq)
    else $error("fired before interval elapsed");
  tick_decrements_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && tick && count_reg > 6'h01 && !port_wr && !port_rd |=> count_reg == $past(count_reg) - 6'h01)
    else $error("count not decremented on tick");
  mode_exclusive_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(cpu_reset && cpu_irq))
    else $error("reset and interrupt both active");
  idle_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running && !port_wr |=> !running)
    else $error("watchdog started without write");
  restart_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && port_wr |=> count_reg == $past(io_req.wdata[5:0]) && !cpu_reset)
    else $error("restart did not reload");

  // ****************************************
  // Further checks
  // ****************************************
  // Cycles since last tick or restart, mirrors the divider phase
  logic [iowdt_pkg::IOWDT_TICK_W-1:0] gap_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= '0;
    end else if (port_wr || tick) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick |-> gap_reg == iowdt_pkg::IOWDT_TICK_W'(TICK_CYCLES - 1))
    else $error("tick period wrong");
  fired_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == iowdt_pkg::IOWDT_FIRED && !port_wr && !port_rd |=> state_reg == iowdt_pkg::IOWDT_FIRED)
    else $error("fired state dropped");
  irq_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == iowdt_pkg::IOWDT_FIRED |-> cpu_irq == irq_mode && cpu_reset == !irq_mode)
    else $error("expiry action does not follow mode");
  rdata_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    port_rd |=> io_rdata == {2'b00, $past(count_reg)})
    else $error("read data not remaining count");
  other_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    !hit && !tick |=> count_reg == $past(count_reg) && state_reg == $past(state_reg))
    else $error("other address changed watchdog");
  idle_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    !running && !port_wr |=> count_reg == $past(count_reg))
    else $error("count moved while disabled");
  no_tick_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    running && !tick && !port_rd |=> running)
    else $error("stopped without tick or read");
  state_onehot_a: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(state_reg))
    else $error("state not one-hot");

  restart_c: cover property (@(posedge clk) disable iff (sys_rst) port_wr && running);
  arm_c: cover property (@(posedge clk) disable iff (sys_rst) port_wr && !running);
  fire_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(cpu_reset));
  irq_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(cpu_irq));
  disable_c: cover property (@(posedge clk) disable iff (sys_rst) port_rd && running);
endmodule // iowdt_top

// ==== tb/iowdt_top_tb.sv ====
// Self-checking bench for the I/O port watchdog
`timescale 1ns/10ps
module iowdt_top_tb;
  localparam int T = 10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  iowdt_pkg::iowdt_io_req_t io_req = '0;
  logic irq_mode = 1'b0;
  logic [7:0] io_rdata;
  logic cpu_reset;
  logic cpu_irq;
  logic running;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int code;
  always #2 clk = ~clk;
  iowdt_top #(.TICK_CYCLES(T)) i_dut (.clk(clk), .sys_rst(sys_rst), .io_req(io_req), .irq_mode(irq_mode),
    .io_rdata(io_rdata), .cpu_reset(cpu_reset), .cpu_irq(cpu_irq), .running(running));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One-cycle port access, driven at the falling edge
  task automatic access(input logic wr, input logic rd, input logic [15:0] addr, input logic [7:0] data);
    io_req = '{wr: wr, rd: rd, addr: addr, wdata: data};
    @(negedge clk);
    io_req.wr = 1'b0;
    io_req.rd = 1'b0;
  endtask
  // Outputs just before and just after expiry of code n
  task automatic expire(input int n);
    repeat (n * T - 2) @(negedge clk);
    chk("running before expiry", {7'h00, running}, 8'h01);
    chk("reset before expiry", {7'h00, cpu_reset}, 8'h00);
    repeat (2) @(negedge clk);
    chk("cpu_reset on expiry", {7'h00, cpu_reset}, {7'h00, ~irq_mode});
    chk("cpu_irq on expiry", {7'h00, cpu_irq}, {7'h00, irq_mode});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h3897));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    chk("running after reset", {7'h00, running}, 8'h00);
    access(1'b1, 1'b0, 16'h0442, 8'h01);
    repeat (T + 3) @(negedge clk);
    chk("running, other address", {7'h00, running}, 8'h00);
    chk("reset, other address", {7'h00, cpu_reset}, 8'h00);
    $display("Test address decode done");
    // Boundary codes, then random ones, each in a randomly chosen expiry mode
    for (int i = 0; i < 5; i++) begin
      code = (i == 0) ? 1 : (i == 1) ? 63 : $urandom_range(2, 8);
      irq_mode = 1'($urandom_range(0, 1));
      access(1'b1, 1'b0, iowdt_pkg::IOWDT_PORT_ADDR, 8'(code));
      chk("running after write", {7'h00, running}, 8'h01);
      expire(code);
      access(1'b0, 1'b1, iowdt_pkg::IOWDT_PORT_ADDR, 8'h00);
      chk("fired cleared by read", {6'h00, cpu_irq, cpu_reset}, 8'h00);
    end
    $display("Test interval codes done");
    irq_mode = 1'b0;
    access(1'b1, 1'b0, iowdt_pkg::IOWDT_PORT_ADDR, 8'h02);
    repeat (15) @(negedge clk);
    access(1'b1, 1'b0, iowdt_pkg::IOWDT_PORT_ADDR, 8'h01);
    expire(1);
    $display("Test restart done");
    access(1'b1, 1'b0, iowdt_pkg::IOWDT_PORT_ADDR, 8'h03);
    repeat (11) @(negedge clk);
    access(1'b0, 1'b1, iowdt_pkg::IOWDT_PORT_ADDR, 8'h00);
    chk("remaining count", io_rdata, 8'(3 - 11 / T));
    chk("running after read", {7'h00, running}, 8'h00);
    repeat (5 * T) @(negedge clk);
    chk("reset while disabled", {6'h00, cpu_irq, cpu_reset}, 8'h00);
    $display("Test disable done");
    give_verdict();
  end
endmodule // iowdt_top_tb
